/* File: src/msc_motor_startup_config.sv */
// Motor start-up configuration register and its decoded control outputs.
// Assumes the serial engine presents single-cycle read and write strobes with an
// 8-bit register address, all synchronous to clk_sys.
// Operation
// RULE_01 - Bits 15:14 pick advance 30, 60, 90 or 120 degrees after sensing.
// RULE_02 - Threshold field zero skips position sensing; rotor aligns, then drives.
// RULE_03 - Threshold code 1 is 0.4 A; codes 2 to 15 are 0.2 A times code+1.
// RULE_04 - Bits 9:8 pick 12/24/47/95 Hz with 2.56/1.28/0.64/0.32 us resolution.
// RULE_05 - Bit 7 reserved: reads zero, host must not touch it.
// RULE_06 - Bits 6:5 set loop constant 0.25, 0.5, 0.75 or 1.
// RULE_07 - Dead time equals field plus one times 40 ns.
// RULE_08 - Register at address 0x96, resets to zero.
`timescale 1ns/1ps
`default_nettype none
module msc_motor_startup_config
    import msc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic [15:0] cfg_word,
    output logic [6:0] post_sense_advance_angle,
    output logic initial_position_detect_skip,
    output logic [4:0] sense_current_threshold,
    output logic [6:0] sense_pulse_rate,
    output logic [11:0] sense_resolution_ns,
    output logic [2:0] loop_gain_constant,
    output logic [7:0] driver_dead_interval
);

    // Advance angle in degrees: one 30 degree step per code.
    function automatic logic [6:0] adv_deg(input logic [1:0] code);
        return 7'((code + 3'h1) * MSC_ADV_STEP_DEG); // [RULE_01]
    endfunction

    // Threshold in 0.2 A units; code 1 is the 0.4 A special case.
    function automatic logic [4:0] thr_units(input logic [3:0] code);
        if (code == MSC_THR_CODE_MIN) begin
            return MSC_THR_MIN_UNITS; // [RULE_03]
        end
        return (code == 4'h0) ? 5'h00 : 5'(code + 5'h01); // [RULE_03]
    endfunction

    function automatic logic [6:0] rate_hz(input logic [1:0] code);
        unique case (code)
            2'h0: return MSC_RATE_HZ_0;
            2'h1: return MSC_RATE_HZ_1;
            2'h2: return MSC_RATE_HZ_2;
            2'h3: return MSC_RATE_HZ_3;
        endcase
    endfunction

    function automatic logic [11:0] res_ns(input logic [1:0] code);
        unique case (code)
            2'h0: return MSC_RES_NS_0;
            2'h1: return MSC_RES_NS_1;
            2'h2: return MSC_RES_NS_2;
            2'h3: return MSC_RES_NS_3;
        endcase
    endfunction

    function automatic logic [7:0] dead_cyc(input logic [4:0] code);
        return 8'((code + 6'h01) * MSC_DEAD_STEP_CYC); // [RULE_07]
    endfunction

    msc_state_t st_r;
    msc_state_t st_nxt;
    logic wr_hit;
    logic [15:0] cfg_n;

    assign wr_hit = reg_wr_en && (reg_addr == MSC_ADDR); // [RULE_08]

    always_comb begin
        st_nxt = st_r;
        cfg_n = st_r.cfg;
        if (wr_hit) begin
            // Reserved bit is never stored, so it reads back as zero.
            cfg_n = reg_wdata & MSC_WR_MASK; // [RULE_05]
        end
        st_nxt.cfg = cfg_n;
        st_nxt.rvalid = reg_rd_en;
        if (reg_rd_en) begin
            // Unmapped addresses answer zero so the serial engine never stalls.
            st_nxt.rdata = (reg_addr == MSC_ADDR) ? st_r.cfg : 16'h0000;
        end
        // Decoded outputs follow the new word in the same edge as the store.
        st_nxt.advance_deg = adv_deg(cfg_n[MSC_ADV_MSB:MSC_ADV_LSB]); // [RULE_01]
        st_nxt.sense_skip = (cfg_n[MSC_THR_MSB:MSC_THR_LSB] == 4'h0); // [RULE_02]
        st_nxt.thr_units = thr_units(cfg_n[MSC_THR_MSB:MSC_THR_LSB]); // [RULE_03]
        st_nxt.rate_hz = rate_hz(cfg_n[MSC_CLK_MSB:MSC_CLK_LSB]); // [RULE_04]
        st_nxt.res_ns = res_ns(cfg_n[MSC_CLK_MSB:MSC_CLK_LSB]); // [RULE_04]
        st_nxt.gain_quarters = 3'(cfg_n[MSC_GAIN_MSB:MSC_GAIN_LSB] + 3'h1); // [RULE_06]
        st_nxt.dead_cycles = dead_cyc(cfg_n[MSC_DEAD_MSB:MSC_DEAD_LSB]); // [RULE_07]
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.cfg <= MSC_RESET; // [RULE_08]
            st_r.advance_deg <= MSC_ADV_STEP_DEG;
            st_r.sense_skip <= 1'b1;
            st_r.rate_hz <= MSC_RATE_HZ_0;
            st_r.res_ns <= MSC_RES_NS_0;
            st_r.gain_quarters <= 3'h1;
            st_r.dead_cycles <= MSC_DEAD_STEP_CYC;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign cfg_word = st_r.cfg;
    assign post_sense_advance_angle = st_r.advance_deg;
    assign initial_position_detect_skip = st_r.sense_skip;
    assign sense_current_threshold = st_r.thr_units;
    assign sense_pulse_rate = st_r.rate_hz;
    assign sense_resolution_ns = st_r.res_ns;
    assign loop_gain_constant = st_r.gain_quarters;
    assign driver_dead_interval = st_r.dead_cycles;

    sequence s_write_taken;
        ce && wr_hit;
    endsequence

    sequence s_read_taken;
        ce && reg_rd_en && (reg_addr == MSC_ADDR) && !wr_hit;
    endsequence

    AST_ADVANCE: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_01]
        post_sense_advance_angle == 7'((cfg_word[15:14] + 3'h1) * 7'h1E))
        else $error("advance angle does not match field");

    AST_SKIP: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_02]
        initial_position_detect_skip == (cfg_word[13:10] == 4'h0))
        else $error("sense skip does not match threshold field");

    AST_THRESHOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_03]
        (cfg_word[13:10] > 4'h1) |-> sense_current_threshold == 5'(cfg_word[13:10] + 5'h01))
        else $error("threshold units wrong");

    AST_THRESHOLD_MIN: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_03]
        (cfg_word[13:10] == 4'h1) |-> sense_current_threshold == 5'h02)
        else $error("0.4 A threshold wrong");

    AST_RATE: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_04]
        (cfg_word[9:8] == 2'h3) |-> sense_pulse_rate == 7'h5F && sense_resolution_ns == 12'h140)
        else $error("fastest sensing clock wrong");

    // The host leaves idle cycles between accesses, so the read may trail the write.
    AST_RSVD_READ: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_05]
        s_write_taken ##[1:4] s_read_taken |=> !reg_rdata[MSC_RSVD_BIT])
        else $error("reserved bit read back nonzero");

    AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        s_read_taken |=> reg_rvalid && reg_rdata == $past(cfg_word))
        else $error("read data does not match register");

    AST_GAIN: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_06]
        loop_gain_constant == 3'(cfg_word[6:5] + 3'h1))
        else $error("loop gain wrong");

    AST_DEAD: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_07]
        s_write_taken |=> driver_dead_interval == 8'(($past(reg_wdata[4:0]) + 6'h01) * 8'h05))
        else $error("dead interval wrong after write");

    AST_RESET_VAL: assert property (@(posedge clk_sys) // [RULE_08]
        $rose(rstn) |-> cfg_word == 16'h0000 && driver_dead_interval == 8'h05)
        else $error("reset value wrong");

    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        !ce |=> $stable(cfg_word))
        else $error("register changed while clock enable low");

    // Read answer is a single pulse; read data holds until the next read with ce high, to any address.
    AST_RVALID_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        (ce && !reg_rd_en) |=> !reg_rvalid)
        else $error("read valid stood longer than one cycle");

    AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        !(ce && reg_rd_en) |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        (ce && reg_rd_en && reg_addr != MSC_ADDR) |=> reg_rvalid && reg_rdata == 16'h0000)
        else $error("unmapped read did not answer zero");

    AST_WRITE_STORE: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_05]
        s_write_taken |=> cfg_word == ($past(reg_wdata) & 16'hFF7F))
        else $error("stored word does not match write data");

    AST_CFG_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
        !(ce && wr_hit) |=> $stable(cfg_word))
        else $error("register changed without a write to its address");

    AST_THRESHOLD_OFF: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_02]
        (cfg_word[13:10] == 4'h0) |-> sense_current_threshold == 5'h00)
        else $error("threshold nonzero while sensing is skipped");

    AST_RATE_SLOW: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_04]
        (cfg_word[9:8] == 2'h0) |-> sense_pulse_rate == 7'h0C && sense_resolution_ns == 12'hA00)
        else $error("slowest sensing clock wrong");

    AST_RATE_ONE: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_04]
        (cfg_word[9:8] == 2'h1) |-> sense_pulse_rate == 7'h18 && sense_resolution_ns == 12'h500)
        else $error("second sensing clock wrong");

    AST_RATE_TWO: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_04]
        (cfg_word[9:8] == 2'h2) |-> sense_pulse_rate == 7'h2F && sense_resolution_ns == 12'h280)
        else $error("third sensing clock wrong");

    AST_DEAD_MAX: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_07]
        (cfg_word[4:0] == 5'h1F) |-> driver_dead_interval == 8'hA0)
        else $error("longest dead interval is not 1.28 us");

    AST_RDATA_RESET: assert property (@(posedge clk_sys) // [RULE_08]
        $rose(rstn) |-> reg_rdata == 16'h0000 && !reg_rvalid)
        else $error("read port not cleared by reset");

endmodule // msc_motor_startup_config
`default_nettype wire

/* File: src/msc_pkg.sv */
// Constants for the motor start-up configuration register.
// Assumes a register port driven by the device's two-wire serial engine.
`default_nettype none
package msc_pkg;
    localparam logic [7:0] MSC_ADDR = 8'h96;
    localparam logic [15:0] MSC_RESET = 16'h0000;
    localparam int MSC_ADV_MSB = 15;
    localparam int MSC_ADV_LSB = 14;
    localparam int MSC_THR_MSB = 13;
    localparam int MSC_THR_LSB = 10;
    localparam int MSC_CLK_MSB = 9;
    localparam int MSC_CLK_LSB = 8;
    localparam int MSC_RSVD_BIT = 7;
    localparam int MSC_GAIN_MSB = 6;
    localparam int MSC_GAIN_LSB = 5;
    localparam int MSC_DEAD_MSB = 4;
    localparam int MSC_DEAD_LSB = 0;
    // Writable bits; the reserved bit is masked off.
    localparam logic [15:0] MSC_WR_MASK = 16'hFF7F;
    localparam logic [6:0] MSC_ADV_STEP_DEG = 7'h1E;
    localparam logic [3:0] MSC_THR_CODE_MIN = 4'h1;
    localparam logic [4:0] MSC_THR_MIN_UNITS = 5'h02;
    localparam logic [6:0] MSC_RATE_HZ_0 = 7'h0C;
    localparam logic [6:0] MSC_RATE_HZ_1 = 7'h18;
    localparam logic [6:0] MSC_RATE_HZ_2 = 7'h2F;
    localparam logic [6:0] MSC_RATE_HZ_3 = 7'h5F;
    localparam logic [11:0] MSC_RES_NS_0 = 12'hA00;
    localparam logic [11:0] MSC_RES_NS_1 = 12'h500;
    localparam logic [11:0] MSC_RES_NS_2 = 12'h280;
    localparam logic [11:0] MSC_RES_NS_3 = 12'h140;
    localparam int MSC_CLK_PERIOD_NS = 8;
    localparam int MSC_DEAD_STEP_NS = 40;
    localparam int MSC_DEAD_STEP_CYC_I = (MSC_DEAD_STEP_NS + MSC_CLK_PERIOD_NS - 1)
                                         / MSC_CLK_PERIOD_NS;
    localparam logic [7:0] MSC_DEAD_STEP_CYC = 8'(MSC_DEAD_STEP_CYC_I);

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rdata;
        logic rvalid;
        logic [6:0] advance_deg;
        logic sense_skip;
        logic [4:0] thr_units;
        logic [6:0] rate_hz;
        logic [11:0] res_ns;
        logic [2:0] gain_quarters;
        logic [7:0] dead_cycles;
    } msc_state_t;
endpackage
`default_nettype wire

/* File: testbench/msc_host_model.sv */
// Host controller model that issues register strobes to the start-up config register.
// Assumes the bench calls its tasks and that requests are sampled on rising clk_sys.
`timescale 1ns/1ps
`default_nettype none
module msc_host_model
    import msc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [15:0] reg_wdata,
    output logic reg_rd_en
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd_en = 1'b0;
    end
    // A real host leaves the reserved bit clear; rsvd lets a scenario break that.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic rsvd);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= rsvd ? d : (d & 16'hFF7F);
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule // msc_host_model
`default_nettype wire

/* File: testbench/msc_motor_startup_config_bench.sv */
// Self-checking bench for the start-up config register and its decoded outputs.
// Assumes msc_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module msc_motor_startup_config_bench
    import msc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr;
    logic reg_wr_en, reg_rd_en, reg_rvalid, skip, v;
    logic [15:0] reg_wdata, reg_rdata, cfg_word, d, w;
    logic [6:0] adv, rate;
    logic [4:0] thr;
    logic [11:0] res;
    logic [2:0] gain;
    logic [7:0] dead;
    logic [6:0] rt[4] = '{7'h0C, 7'h18, 7'h2F, 7'h5F};
    logic [11:0] rs[4] = '{12'hA00, 12'h500, 12'h280, 12'h140};
    int miscompares = 0;
    int checked = 0;
    always #4 clk_sys = ~clk_sys;
    msc_host_model i_msc_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
    msc_motor_startup_config i_msc_motor_startup_config (.clk_sys(clk_sys), .rstn(rstn),
        .ce(ce), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cfg_word(cfg_word), .post_sense_advance_angle(adv),
        .initial_position_detect_skip(skip), .sense_current_threshold(thr),
        .sense_pulse_rate(rate), .sense_resolution_ns(res), .loop_gain_constant(gain),
        .driver_dead_interval(dead));
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Threshold in 0.2 A units: code 1 is 0.4 A, higher codes are code plus one.
    function automatic int thr_exp(input int t);
        return (t == 0) ? 0 : ((t == 1) ? 2 : t + 1);
    endfunction
    // Dead interval in clock cycles; the dead step is 40 ns over an 8 ns clock.
    function automatic int dead_exp(input int n);
        return (n + 1) * 5;
    endfunction
    // Expected decode of a stored word.
    task automatic outs(input logic [15:0] x);
        int t;
        t = x[13:10];
        chk(cfg_word, x & 16'hFF7F);
        chk(16'(adv), 16'(30 * (x[15:14] + 1)));
        chk(16'(skip), 16'(t == 0));
        chk(16'(thr), 16'(thr_exp(t)));
        chk(16'(rate), 16'(rt[x[9:8]]));
        chk(16'(res), 16'(rs[x[9:8]]));
        chk(16'(gain), 16'(x[6:5] + 1));
        chk(16'(dead), 16'(dead_exp(x[4:0])));
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        i_msc_host_model.rd(a, d, v);
        chk(16'(v), 16'h0001);
        chk(d, exp);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
    initial begin
        void'($urandom(11));
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        outs(16'h0000);
        rd_chk(MSC_ADDR, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            w = 16'($urandom);
            if (i < 16) w[13:10] = 4'(i);
            w[15:14] = 2'(i);
            w[9:8] = 2'(i >> 2);
            w[6:5] = 2'(i >> 1);
            if (i == 1) w[4:0] = 5'h1F;
            if (i == 3) w[7] = 1'b1;
            i_msc_host_model.wr(MSC_ADDR, w, i == 3);
            rd_chk(MSC_ADDR, w & 16'hFF7F);
            outs(w);
        end
        i_msc_host_model.wr(8'h95, 16'hFFFF, 1'b0);
        rd_chk(MSC_ADDR, w & 16'hFF7F);
        rd_chk(8'h97, 16'h0000);
        @(posedge clk_sys) ce <= 1'b0;
        i_msc_host_model.wr(MSC_ADDR, ~w, 1'b0);
        ce <= 1'b1;
        @(posedge clk_sys);
        #1;
        outs(w);
        @(posedge clk_sys) rstn <= 1'b0;
        @(posedge clk_sys) rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        outs(16'h0000);
        chk(reg_rdata, 16'h0000);
        chk(16'(reg_rvalid), 16'h0000);
        report_and_stop();
    end
endmodule // msc_motor_startup_config_bench
`default_nettype wire
